//--- dv/probe_driver.sv
`timescale 1ns/1ps
module probe_driver (
  input  wire logic        clock,
  input  wire logic [15:0] probe_set,
  input  wire logic        ext_req,
  output logic      [15:0] probe,
  output logic             external_trigger_input
);
  // ----------------------------------------
  // User logic: registered probes, trigger held three cycles
  // ----------------------------------------
  logic [1:0] hold_r = 2'h0;
  initial probe = 16'h0;
  always @(posedge clock) begin
    probe <= probe_set;
    if (ext_req) hold_r <= 2'h3;
    else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
  end
  // Held past the synchroniser so the rise is never missed
  assign external_trigger_input = hold_r != 2'h0;
endmodule // probe_driver

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int DEP = 64;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] probe, probe_set = 16'h0, v;
  logic        ext, ext_req = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, e_m, m_m;
  logic        trigger_out, irq, rd_d = 1'b0;
  logic [31:0] exp_q[$], msk_q[$];
  int          n_errors = 0, checks_done = 0, n_fire = 0, f0;
  capture_pkg::seq_step_t step;
  logic [2:0]  md[5] = '{3'h0, 3'h0, 3'h1, 3'h3, 3'h4};
  logic [31:0] ct[5] = '{32'h11, 32'h19, 32'h11, 32'h11, 32'h11};
  logic [15:0] hit[5] = '{16'h0, 16'hfffe, 16'h0, 16'hffff, 16'hffff};
  always #2.5 clock = ~clock;
  trigger_capture #(.WIDTH(16), .DEPTH(DEP), .AW(6), .MAX_WIN(8)) dut (
    .clock(clock), .reset_n(reset_n), .probe(probe),
    .external_trigger_input(ext), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .trigger_out(trigger_out), .irq(irq));
  probe_driver drv (.clock(clock), .probe_set(probe_set),
    .ext_req(ext_req), .probe(probe), .external_trigger_input(ext));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic pulse();
    @(posedge clock);
    ext_req <= 1'b1;
    @(posedge clock);
    ext_req <= 1'b0;
  endtask
  task automatic wait_trig();
    int i;
    i = 0;
    while (trigger_out !== 1'b1 && i < 300) begin
      @(posedge clock);
      i++;
    end
    chk({31'h0, trigger_out}, 32'h1);
  endtask
  task automatic summarize();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Result monitor: read data stands one cycle
  // ----------------------------------------
  always @(posedge clock) begin
    if (rd_d) begin
      e_m = exp_q.pop_front();
      m_m = msk_q.pop_front();
      chk(reg_rdata & m_m, e_m & m_m);
    end
    if (trigger_out === 1'b1) n_fire++;
    rd_d <= reg_read;
  end
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(53362));
    cyc(16);
    reset_n <= 1'b1;
    rd(capture_pkg::ADDR_WINDOWS, 32'h1, 32'hffffffff);
    rd(capture_pkg::ADDR_DEPTH, DEP, 32'hffffffff);
    rd(capture_pkg::ADDR_STATUS, 32'h0, 32'hffffffff);
    rd(8'h48, 32'h0, 32'hffffffff);
    wr(capture_pkg::ADDR_IRQ_MASK, 32'h7);
    wr(capture_pkg::ADDR_TRIG_MODE, 32'h2);
    wr(capture_pkg::ADDR_WINDOWS, 32'h2);
    wr(capture_pkg::ADDR_DEPTH, 32'h4);
    wr(capture_pkg::ADDR_TRIG_POS, 32'h2);
    probe_set <= 16'($urandom);
    wr(capture_pkg::ADDR_CONTROL, 32'h11);
    cyc(10);
    rd(capture_pkg::ADDR_STATUS, 32'h3, 32'hffe00007);
    pulse();
    wait_trig();
    cyc(10);
    rd(capture_pkg::ADDR_STATUS, 32'h00200003, 32'hffe00007);
    pulse();
    wait_trig();
    cyc(10);
    rd(capture_pkg::ADDR_STATUS, 32'h86, 32'hff);
    rd(capture_pkg::ADDR_IRQ_STATUS, 32'h7, 32'hffffffff);
    wr(capture_pkg::ADDR_IRQ_STATUS, 32'h7);
    rd(capture_pkg::ADDR_IRQ_STATUS, 32'h0, 32'hffffffff);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    v = 16'($urandom);
    step = '{fire: 1'b1, next_on_match: 2'h0, next_on_miss: 2'h0,
             mask: 16'h07ff, value: v[10:0]};
    wr(capture_pkg::ADDR_WINDOWS, 32'h1);
    wr(capture_pkg::ADDR_TRIG_POS, 32'h0);
    wr(capture_pkg::ADDR_CMP_MASK, 32'hffff);
    wr(capture_pkg::ADDR_CMP_VALUE, {16'h0, v});
    wr(capture_pkg::ADDR_SEQ_BASE, step);
    for (int k = 0; k < 5; k++) begin
      probe_set <= v ^ 16'hffff;
      wr(capture_pkg::ADDR_TRIG_MODE, {29'h0, md[k]});
      wr(capture_pkg::ADDR_CONTROL, ct[k]);
      f0 = n_fire;
      cyc(10);
      chk(n_fire, f0);
      probe_set <= v ^ hit[k];
      if (md[k] >= 3'h3) pulse();
      wait_trig();
      cyc(10);
      rd(capture_pkg::ADDR_STATUS, 32'h86, 32'hff);
      wr(capture_pkg::ADDR_READ_PTR, 32'h0);
      for (int j = 0; j < 4; j++)
        rd(capture_pkg::ADDR_READ_DATA, 32'(v ^ hit[k]), 32'hffff);
    end
    wr(capture_pkg::ADDR_IRQ_MASK, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    cyc(4);
    summarize();
  end
endmodule // tb_top

//--- dv/trigger_capture_props.sv
`timescale 1ns/1ps
module trigger_capture_props #(
  parameter int WIDTH = 16
) (
  input wire logic             clock,
  input wire logic             reset_n,
  input wire logic [WIDTH-1:0] probe,
  input wire logic             external_trigger_input,
  input wire logic [7:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_write,
  input wire logic             reg_read,
  input wire logic [31:0]      reg_rdata,
  input wire logic             trigger_out,
  input wire logic             irq
);
  // ----------------------------------------
  // Shadow of settings seen on the bus
  // ----------------------------------------
  logic [2:0] mode_r;
  logic [1:0] tout_r;
  logic [2:0] mask_r;
  logic       armed_r;
  wire        wr_ctl = reg_write && reg_addr == capture_pkg::ADDR_CONTROL;
  wire        wr_md  = reg_write && reg_addr == capture_pkg::ADDR_TRIG_MODE;
  wire        wr_msk = reg_write && reg_addr == capture_pkg::ADDR_IRQ_MASK;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_r  <= 3'h0;
      tout_r  <= 2'h0;
      mask_r  <= 3'h0;
      armed_r <= 1'b0;
    end else begin
      if (wr_md) mode_r <= reg_wdata[2:0];
      if (wr_ctl) tout_r <= reg_wdata[5:4];
      if (wr_msk) mask_r <= reg_wdata[2:0];
      if (wr_ctl && reg_wdata[0]) armed_r <= 1'b1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_RDATA_ONLY_AFTER_READ: assert property (
    !$past(reg_read) |-> reg_rdata == 32'h0) else $error("stray rdata");
  AST_UNMAPPED_ZERO: assert property (
    reg_read && reg_addr >= 8'h48 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_EXT_EDGE: assert property (
    mode_r == capture_pkg::external_edge_trigger_mode && $rose(trigger_out)
    |-> $past(external_trigger_input, 3) && !$past(external_trigger_input, 4))
    else $error("fire without external rise");
  AST_PULSE_ONE: assert property (
    tout_r == capture_pkg::TOUT_PULSE && trigger_out |=> !trigger_out)
    else $error("pulse longer than one cycle");
  AST_TOUT_OFF: assert property (
    tout_r == capture_pkg::TOUT_OFF && $past(tout_r) == capture_pkg::TOUT_OFF
    |-> !trigger_out) else $error("trigger out while off");
  AST_IRQ_MASKED: assert property (
    mask_r == 3'h0 |-> !irq) else $error("irq while masked");
  AST_NO_FIRE_UNARMED: assert property (
    !armed_r |-> !trigger_out) else $error("fire before arm");
  AST_IRQ_ON_FIRE: assert property (
    tout_r == capture_pkg::TOUT_PULSE && mask_r[0] && $rose(trigger_out)
    |-> irq) else $error("no irq on fire");
  COV_EXT: cover property (mode_r == 3'h2 && $rose(trigger_out));
  COV_SEQ: cover property (mode_r == 3'h1 && $rose(trigger_out));
  COV_IRQ: cover property ($rose(irq));
endmodule // trigger_capture_props

bind trigger_capture trigger_capture_props #(.WIDTH(WIDTH)) u_props (
  .clock(clock), .reset_n(reset_n), .probe(probe),
  .external_trigger_input(external_trigger_input), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .trigger_out(trigger_out), .irq(irq));

//--- include/capture_pkg.sv
package capture_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_TRIG_MODE  = 8'h04;
  localparam logic [7:0] ADDR_WINDOWS    = 8'h08;
  localparam logic [7:0] ADDR_DEPTH      = 8'h0c;
  localparam logic [7:0] ADDR_TRIG_POS   = 8'h10;
  localparam logic [7:0] ADDR_CMP_MASK   = 8'h14;
  localparam logic [7:0] ADDR_CMP_VALUE  = 8'h18;
  localparam logic [7:0] ADDR_QUAL_MASK  = 8'h1c;
  localparam logic [7:0] ADDR_QUAL_VALUE = 8'h20;
  localparam logic [7:0] ADDR_SEQ_BASE   = 8'h24;
  localparam logic [7:0] ADDR_STATUS     = 8'h34;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h38;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h3c;
  localparam logic [7:0] ADDR_READ_PTR   = 8'h40;
  localparam logic [7:0] ADDR_READ_DATA  = 8'h44;

  localparam int SEQ_STATES = 4;

  // ---------------------------------------------------------------
  // Control bits
  // ---------------------------------------------------------------
  localparam int CTL_ARM       = 0;
  localparam int CTL_STOP      = 1;
  localparam int CTL_CAP_QUAL  = 2;
  localparam int CTL_CMP_OR    = 3;
  localparam int CTL_TOUT_MODE = 4;
  localparam int CTL_TOUT_W    = 2;

  // Interrupt bits
  localparam int IRQ_TRIGGER = 0;
  localparam int IRQ_WINDOW  = 1;
  localparam int IRQ_DONE    = 2;
  localparam int IRQ_W       = 3;

  typedef enum logic [2:0] {
    TRIG_COMPARATOR  = 3'h0,
    TRIG_SEQUENCER   = 3'h1,
    external_edge_trigger_mode = 3'h2,
    comparator_or_external_mode = 3'h3,
    sequencer_or_external_mode  = 3'h4
  } trig_mode_t;

  typedef enum logic [1:0] {
    TOUT_OFF   = 2'h0,
    TOUT_PULSE = 2'h1,
    TOUT_LEVEL = 2'h2,
    TOUT_INV   = 2'h3
  } tout_mode_t;

  // Gray codes along idle-armed-waiting-post-done
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PRE   = 3'b001,
    ST_WAIT  = 3'b011,
    ST_POST  = 3'b010,
    ST_DONE  = 3'b110
  } cap_state_t;

  // One sequencer step: on match go to next, a hit fires the trigger only when fire is set
  typedef struct packed {
    logic        fire;
    logic [1:0]  next_on_match;
    logic [1:0]  next_on_miss;
    logic [15:0] mask;
    logic [10:0] value;
  } seq_step_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } reg_req_t;

endpackage

//--- logic/probe_match.sv
`timescale 1ns/1ps
module probe_match #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] probe,
  input  wire logic [WIDTH-1:0] mask,
  input  wire logic [WIDTH-1:0] value,
  input  wire logic             use_or,
  output logic                  hit
);

  // ---------------------------------------------------------------
  // Per-bit compare, bits with mask clear are don't-care
  // ---------------------------------------------------------------
  wire [WIDTH-1:0] bit_eq  = ~(probe ^ value);
  wire             all_eq  = &(bit_eq | ~mask);
  wire             any_eq  = |(bit_eq & mask);

  assign hit = use_or ? any_eq : all_eq;

endmodule // probe_match

//--- logic/sample_ram.sv
`timescale 1ns/1ps
module sample_ram #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic             clock,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // sample_ram

//--- logic/trigger_capture.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Comparator mode fires when the AND or OR of probe compares holds
// - Sequencer mode fires as the programmed step machine directs
// - External-edge mode fires only on a rising external trigger input
// - Comparator-or-external mode fires on either condition
// - Sequencer-or-external mode fires on either condition
// - Trigger output shape is selectable: off, pulse, level, inverted
// - Capture stores every sample, or only qualified samples
// - Storage splits into one to maximum windows, one trigger each
// - Window depth in samples is configurable within storage
// - Trigger position sets pre-trigger history length in the window
// - Status shows idle, armed, waiting, complete and window count
module trigger_capture #(
  parameter int WIDTH   = 16,
  parameter int DEPTH   = 1024,
  parameter int AW      = 10,
  parameter int MAX_WIN = 1024
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] probe,
  input  wire logic             external_trigger_input,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  output logic      [31:0]      reg_rdata,
  output logic                  trigger_out,
  output logic                  irq
);

  // ---------------------------------------------------------------
  // Bus request bundle and decode
  // ---------------------------------------------------------------
  capture_pkg::reg_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata,
                 write: reg_write, read: reg_read};

  wire wr_ctl   = req.write && req.addr == capture_pkg::ADDR_CONTROL;
  wire wr_mode  = req.write && req.addr == capture_pkg::ADDR_TRIG_MODE;
  wire wr_win   = req.write && req.addr == capture_pkg::ADDR_WINDOWS;
  wire wr_depth = req.write && req.addr == capture_pkg::ADDR_DEPTH;
  wire wr_pos   = req.write && req.addr == capture_pkg::ADDR_TRIG_POS;
  wire wr_cmsk  = req.write && req.addr == capture_pkg::ADDR_CMP_MASK;
  wire wr_cval  = req.write && req.addr == capture_pkg::ADDR_CMP_VALUE;
  wire wr_qmsk  = req.write && req.addr == capture_pkg::ADDR_QUAL_MASK;
  wire wr_qval  = req.write && req.addr == capture_pkg::ADDR_QUAL_VALUE;
  wire wr_ist   = req.write && req.addr == capture_pkg::ADDR_IRQ_STATUS;
  wire wr_imsk  = req.write && req.addr == capture_pkg::ADDR_IRQ_MASK;
  wire wr_rptr  = req.write && req.addr == capture_pkg::ADDR_READ_PTR;
  wire arm_cmd  = wr_ctl && req.wdata[capture_pkg::CTL_ARM];
  wire stop_cmd = wr_ctl && req.wdata[capture_pkg::CTL_STOP];

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic                   cap_qual_r;
  logic                   cmp_or_r;
  capture_pkg::tout_mode_t tout_mode_r;
  capture_pkg::trig_mode_t trig_mode_r;
  logic [AW:0]            windows_r;
  logic [AW:0]            depth_r;
  logic [AW-1:0]          trig_pos_r;
  logic [WIDTH-1:0]       cmp_mask_r;
  logic [WIDTH-1:0]       cmp_value_r;
  logic [WIDTH-1:0]       qual_mask_r;
  logic [WIDTH-1:0]       qual_value_r;
  logic [AW-1:0]          rd_ptr_r;
  logic [capture_pkg::IRQ_W-1:0] irq_mask_r;
  logic [31:0]            seq_prog_r [capture_pkg::SEQ_STATES];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cap_qual_r   <= 1'b0;
      cmp_or_r     <= 1'b0;
      tout_mode_r  <= capture_pkg::TOUT_OFF;
      trig_mode_r  <= capture_pkg::TRIG_COMPARATOR;
      windows_r    <= (AW+1)'(1);
      depth_r      <= (AW+1)'(DEPTH);
      trig_pos_r   <= '0;
      cmp_mask_r   <= '0;
      cmp_value_r  <= '0;
      qual_mask_r  <= '0;
      qual_value_r <= '0;
      irq_mask_r   <= '0;
    end else begin
      if (wr_ctl) begin
        cap_qual_r  <= req.wdata[capture_pkg::CTL_CAP_QUAL];
        cmp_or_r    <= req.wdata[capture_pkg::CTL_CMP_OR];
        tout_mode_r <= capture_pkg::tout_mode_t'(req.wdata[
          capture_pkg::CTL_TOUT_MODE +: capture_pkg::CTL_TOUT_W]);
      end
      if (wr_mode) trig_mode_r <= capture_pkg::trig_mode_t'(req.wdata[2:0]);
      if (wr_win)  windows_r   <= req.wdata[AW:0];
      if (wr_depth) depth_r    <= req.wdata[AW:0];
      if (wr_pos)  trig_pos_r  <= req.wdata[AW-1:0];
      if (wr_cmsk) cmp_mask_r  <= req.wdata[WIDTH-1:0];
      if (wr_cval) cmp_value_r <= req.wdata[WIDTH-1:0];
      if (wr_qmsk) qual_mask_r <= req.wdata[WIDTH-1:0];
      if (wr_qval) qual_value_r <= req.wdata[WIDTH-1:0];
      if (wr_imsk) irq_mask_r  <= req.wdata[capture_pkg::IRQ_W-1:0];
    end
  end

  // Sequencer program words, one per step
  genvar g;
  generate
    for (g = 0; g < capture_pkg::SEQ_STATES; g++) begin : g_seq
      wire wr_step = req.write && req.addr ==
                     capture_pkg::ADDR_SEQ_BASE + 8'(4 * g);
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) seq_prog_r[g] <= '0;
        else if (wr_step) seq_prog_r[g] <= req.wdata;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Probe and external input synchronisers
  // ---------------------------------------------------------------
  // Probes come from the user design clock, so two stages each
  logic [WIDTH-1:0] probe_s1_r, probe_s2_r;
  logic             ext_s1_r, ext_s2_r, ext_prev_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      probe_s1_r <= '0;
      probe_s2_r <= '0;
      ext_s1_r   <= 1'b0;
      ext_s2_r   <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      probe_s1_r <= probe;
      probe_s2_r <= probe_s1_r;
      ext_s1_r   <= external_trigger_input;
      ext_s2_r   <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
    end
  end

  wire ext_rise = ext_s2_r && !ext_prev_r;

  // ---------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------
  logic cmp_hit;
  logic qual_hit;
  logic step_hit;
  capture_pkg::seq_step_t cur_step;
  logic [1:0] seq_state_r;

  assign cur_step = capture_pkg::seq_step_t'(seq_prog_r[seq_state_r]);

  probe_match #(.WIDTH(WIDTH)) u_cmp (
    .probe  (probe_s2_r),
    .mask   (cmp_mask_r),
    .value  (cmp_value_r),
    .use_or (cmp_or_r),
    .hit    (cmp_hit)
  );

  probe_match #(.WIDTH(WIDTH)) u_qual (
    .probe  (probe_s2_r),
    .mask   (qual_mask_r),
    .value  (qual_value_r),
    .use_or (1'b0),
    .hit    (qual_hit)
  );

  // Step compare uses the low probe bits the step word can hold
  probe_match #(.WIDTH(WIDTH)) u_step (
    .probe  (probe_s2_r),
    .mask   (WIDTH'(cur_step.mask)),
    .value  (WIDTH'(cur_step.value)),
    .use_or (1'b0),
    .hit    (step_hit)
  );

  // ---------------------------------------------------------------
  // Capture state machine
  // ---------------------------------------------------------------
  capture_pkg::cap_state_t state_r, state_nxt;
  logic [AW-1:0] wr_ptr_r;
  logic [AW:0]   fill_r;
  logic [AW:0]   post_r;
  logic [AW:0]   win_idx_r;
  logic [AW-1:0] win_base_r;
  logic [AW-1:0] trig_addr_r;

  wire waiting  = state_r == capture_pkg::ST_WAIT;
  wire seq_fire = step_hit && cur_step.fire;

  // Sequencer steps only while waiting for trigger
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) seq_state_r <= '0;
    else if (!waiting) seq_state_r <= '0;
    else seq_state_r <= step_hit ? cur_step.next_on_match
                                 : cur_step.next_on_miss;
  end

  logic trig_cond;
  always_comb begin
    unique case (trig_mode_r)
      capture_pkg::TRIG_COMPARATOR: trig_cond = cmp_hit;
      capture_pkg::TRIG_SEQUENCER:  trig_cond = seq_fire;
      capture_pkg::external_edge_trigger_mode:
        trig_cond = ext_rise;
      capture_pkg::comparator_or_external_mode:
        trig_cond = ext_rise || cmp_hit;
      capture_pkg::sequencer_or_external_mode:
        trig_cond = ext_rise || seq_fire;
      default: trig_cond = 1'b0;
    endcase
  end

  // Qualified mode stores only matching samples
  wire keep      = !cap_qual_r || qual_hit;
  wire capturing = state_r inside {capture_pkg::ST_PRE,
                                   capture_pkg::ST_WAIT,
                                   capture_pkg::ST_POST};
  wire store     = capturing && keep;
  wire fire      = waiting && trig_cond;
  // Window full once the post part, trigger sample included, is stored
  wire win_full  = store && (post_r + (AW+1)'(1) >=
                             depth_r - (AW+1)'(trig_pos_r));
  wire last_win  = win_idx_r + (AW+1)'(1) >= windows_r;
  wire pre_done  = store &&
                   (fill_r + (AW+1)'(1) >= (AW+1)'(trig_pos_r));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      capture_pkg::ST_IDLE: if (arm_cmd) state_nxt = capture_pkg::ST_PRE;
      capture_pkg::ST_PRE: begin
        if (trig_pos_r == '0 || pre_done) state_nxt = capture_pkg::ST_WAIT;
      end
      capture_pkg::ST_WAIT: if (fire) state_nxt = capture_pkg::ST_POST;
      capture_pkg::ST_POST: begin
        if (win_full) begin
          state_nxt = last_win ? capture_pkg::ST_DONE
                               : capture_pkg::ST_PRE;
        end
      end
      capture_pkg::ST_DONE: if (arm_cmd) state_nxt = capture_pkg::ST_PRE;
      default: state_nxt = capture_pkg::ST_IDLE;
    endcase
    if (stop_cmd) state_nxt = capture_pkg::ST_IDLE;
  end

  // Pre-trigger history wraps inside the window until trigger
  wire [AW:0] fill_wrap = (fill_r + (AW+1)'(1) >= depth_r) ? '0
                          : fill_r + (AW+1)'(1);
  wire        new_win   = state_r == capture_pkg::ST_POST && win_full;
  wire        start     = arm_cmd && (state_r == capture_pkg::ST_IDLE ||
                                      state_r == capture_pkg::ST_DONE);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= capture_pkg::ST_IDLE;
      fill_r      <= '0;
      post_r      <= '0;
      win_idx_r   <= '0;
      win_base_r  <= '0;
      trig_addr_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        fill_r     <= '0;
        win_idx_r  <= '0;
        win_base_r <= '0;
      end else if (new_win) begin
        fill_r     <= '0;
        win_idx_r  <= win_idx_r + (AW+1)'(1);
        win_base_r <= win_base_r + depth_r[AW-1:0];
      end else if (store) begin
        // One ring per window, so a late trigger keeps newest history
        fill_r <= fill_wrap;
      end
      if (start || new_win) post_r <= '0;
      else if (store && (fire || state_r == capture_pkg::ST_POST))
        post_r <= post_r + (AW+1)'(1);
      if (fire) trig_addr_r <= wr_ptr_r;
    end
  end

  assign wr_ptr_r = win_base_r + fill_r[AW-1:0];

  // ---------------------------------------------------------------
  // Trigger output
  // ---------------------------------------------------------------
  logic trig_seen_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) trig_seen_r <= 1'b0;
    else if (start || stop_cmd) trig_seen_r <= 1'b0;
    else if (fire) trig_seen_r <= 1'b1;
  end

  logic tout_nxt;
  always_comb begin
    unique case (tout_mode_r)
      capture_pkg::TOUT_OFF:   tout_nxt = 1'b0;
      capture_pkg::TOUT_PULSE: tout_nxt = fire;
      capture_pkg::TOUT_LEVEL: tout_nxt = trig_seen_r || fire;
      capture_pkg::TOUT_INV:   tout_nxt = !fire;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) trigger_out <= 1'b0;
    else trigger_out <= tout_nxt;
  end

  // ---------------------------------------------------------------
  // Sample storage and readback
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] ram_rdata;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) rd_ptr_r <= '0;
    else if (wr_rptr) rd_ptr_r <= req.wdata[AW-1:0];
    // Auto-advance lets software stream the buffer out
    else if (req.read && req.addr == capture_pkg::ADDR_READ_DATA)
      rd_ptr_r <= rd_ptr_r + AW'(1);
  end

  sample_ram #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_ram (
    .clock   (clock),
    .wr_en   (store),
    .wr_addr (wr_ptr_r),
    .wr_data (probe_s2_r),
    .rd_addr (rd_ptr_r),
    .rd_data (ram_rdata)
  );

  // ---------------------------------------------------------------
  // Interrupts, set wins over clear
  // ---------------------------------------------------------------
  logic [capture_pkg::IRQ_W-1:0] irq_stat_r;
  logic [capture_pkg::IRQ_W-1:0] irq_set;
  assign irq_set = {state_nxt == capture_pkg::ST_DONE &&
                    state_r != capture_pkg::ST_DONE,
                    new_win, fire};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) irq_stat_r <= '0;
    else irq_stat_r <= (irq_stat_r &
                        ~(wr_ist ? req.wdata[capture_pkg::IRQ_W-1:0] : '0))
                       | irq_set;
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  wire [31:0] status_word = {11'(win_idx_r), 13'h0000, trig_seen_r,
                             4'h0, 3'(state_r)};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (req.addr)
      capture_pkg::ADDR_CONTROL:    rd_mux = 32'({tout_mode_r, cmp_or_r,
                                                  cap_qual_r, 2'b00});
      capture_pkg::ADDR_TRIG_MODE:  rd_mux = 32'(trig_mode_r);
      capture_pkg::ADDR_WINDOWS:    rd_mux = 32'(windows_r);
      capture_pkg::ADDR_DEPTH:      rd_mux = 32'(depth_r);
      capture_pkg::ADDR_TRIG_POS:   rd_mux = 32'(trig_pos_r);
      capture_pkg::ADDR_CMP_MASK:   rd_mux = 32'(cmp_mask_r);
      capture_pkg::ADDR_CMP_VALUE:  rd_mux = 32'(cmp_value_r);
      capture_pkg::ADDR_QUAL_MASK:  rd_mux = 32'(qual_mask_r);
      capture_pkg::ADDR_QUAL_VALUE: rd_mux = 32'(qual_value_r);
      capture_pkg::ADDR_STATUS:     rd_mux = status_word;
      capture_pkg::ADDR_IRQ_STATUS: rd_mux = 32'(irq_stat_r);
      capture_pkg::ADDR_IRQ_MASK:   rd_mux = 32'(irq_mask_r);
      capture_pkg::ADDR_READ_PTR:   rd_mux = 32'(trig_addr_r);
      default:                      rd_mux = 32'h0000_0000;
    endcase
  end

  // Sample data is already registered in the RAM, one cycle late
  logic data_sel_r;
  logic [31:0] rd_hold_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      data_sel_r <= 1'b0;
      rd_hold_r  <= '0;
    end else begin
      data_sel_r <= req.read && req.addr == capture_pkg::ADDR_READ_DATA;
      rd_hold_r  <= req.read ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = data_sel_r ? 32'(ram_rdata) : rd_hold_r;

endmodule // trigger_capture
